/* File: rtl/cct_defines.vh */
// Constants for the capture/compare timer: addresses, fields, reset values
`ifndef CCT_DEFINES_VH
`define CCT_DEFINES_VH

// Register addresses on the plain register port
`define CCT_ADDR_IER 4'h0
`define CCT_ADDR_CSR 4'h1
`define CCT_ADDR_CNT 4'h2
`define CCT_ADDR_CMP 4'h3
`define CCT_ADDR_CTL 4'h4
`define CCT_ADDR_OCTL 4'h5
`define CCT_ADDR_CAPA 4'h6
`define CCT_ADDR_CAPB 4'h7
`define CCT_ADDR_CAPC 4'h8
`define CCT_ADDR_CAPD 4'h9

// Flag positions, shared by the status and interrupt enable registers; bit 0 is the status register's counter clear select
`define CCT_F_CAPA 7
`define CCT_F_CAPB 6
`define CCT_F_CAPC 5
`define CCT_F_CAPD 4
`define CCT_F_CMPA 3
`define CCT_F_CMPB 2
`define CCT_F_OVF 1
`define CCT_CSR_CCLR 0

// Control register fields
`define CCT_CTL_EDGA 7
`define CCT_CTL_EDGB 6
`define CCT_CTL_EDGC 5
`define CCT_CTL_EDGD 4
`define CCT_CTL_BUFA 3
`define CCT_CTL_BUFB 2
`define CCT_CTL_CKS_HI 1
`define CCT_CTL_CKS_LO 0

// Clock select codes
`define CCT_CKS_DIV2 2'h0
`define CCT_CKS_DIV8 2'h1
`define CCT_CKS_DIV32 2'h2
`define CCT_CKS_EXT 2'h3

// Prescaler masks: a tick when the masked bits are all ones
`define CCT_DIV2_MASK 5'h01
`define CCT_DIV8_MASK 5'h07
`define CCT_DIV32_MASK 5'h1f

// Output control register fields
`define CCT_OCTL_DMASK 7
`define CCT_OCTL_AUTO 6
`define CCT_OCTL_CAPSEL 5
`define CCT_OCTL_CMPSEL 4
`define CCT_OCTL_OEA 3
`define CCT_OCTL_OEB 2
`define CCT_OCTL_LVLA 1
`define CCT_OCTL_LVLB 0

// Reset values, plus the counter maximum and the reserved IER read value
`define CCT_RST_CNT 16'h0000
`define CCT_RST_CMP 16'hffff
`define CCT_RST_CAP 16'h0000
`define CCT_RST_STEP 16'hffff
`define CCT_RST_SPAN 8'h00
`define CCT_CNT_MAX 16'hffff
`define CCT_IER_RSVD 8'h01

`endif

/* File: rtl/cct_pin_sync.v */
// Two-flop synchroniser and edge detector for a group of pins
`timescale 1ns/1ps
module cct_pin_sync #(
    parameter WIDTH = 5
) (
    input wire clock,
    input wire resetn,
    input wire [WIDTH-1:0] pin,
    output reg [WIDTH-1:0] level,
    output wire [WIDTH-1:0] rise,
    output wire [WIDTH-1:0] fall
);
    reg [WIDTH-1:0] meta;
    reg [WIDTH-1:0] prev;

    // Only the second stage and later are looked at by any logic
    always @(posedge clock) begin
        if (!resetn) begin
            meta <= {WIDTH{1'b0}};
            level <= {WIDTH{1'b0}};
            prev <= {WIDTH{1'b0}};
        end else begin
            meta <= pin;
            level <= meta;
            prev <= level;
        end
    end

    // Edges from successive sampled values
    assign rise = level & ~prev;
    assign fall = ~level & prev;
endmodule // cct_pin_sync

/* File: rtl/cct_timer.v */
// Free-running capture/compare timer with register port and pins
`timescale 1ns/1ps
`include "cct_defines.vh"
module cct_timer (
    input wire clock,
    input wire resetn,
    input wire [3:0] addr,
    input wire [15:0] wr_data,
    input wire wr_en,
    input wire rd_en,
    output reg [15:0] rd_data,
    input wire ext_count_clock_pin,
    input wire capture_a_pin,
    input wire capture_b_pin,
    input wire capture_c_pin,
    input wire capture_d_pin,
    output reg compare_a_pin,
    output reg compare_b_pin,
    output reg [6:0] irq_req
);

    // Edge select: 1 picks the rising edge, 0 the falling one
    function edge_hit;
        input sel;
        input rise;
        input fall;
        begin
            edge_hit = sel ? rise : fall;
        end
    endfunction

    // Register write decode
    function wr_hit;
        input en;
        input [3:0] a;
        input [3:0] target;
        begin
            wr_hit = en && (a == target);
        end
    endfunction

    // Register state
    reg [15:0] count_value;
    reg [15:0] compare_a_value;
    reg [15:0] compare_b_value;
    reg [15:0] capture_a_value;
    reg [15:0] capture_b_value;
    reg [15:0] capture_c_value;
    reg [15:0] capture_d_value;
    reg [15:0] compare_a_rise_step;
    reg [15:0] compare_a_fall_step;
    reg [7:0] capture_d_mask_span;
    reg [7:1] interrupt_enable_reg;
    reg [7:1] flags;
    reg counter_clear_sel;
    reg [7:0] control_reg;
    reg [7:0] output_control_reg;

    // Internal state
    reg [4:0] prescale;
    reg count_moved;
    reg add_fall_next;
    reg auto_prev;
    reg mask_active;
    reg [15:0] mask_end;

    wire [4:0] pin_rise;
    wire [4:0] pin_fall;

    // Pin order: 0 ext clock, 1..4 capture A..D
    cct_pin_sync #(
        .WIDTH(5)
    ) u_pin_sync (
        .clock(clock),
        .resetn(resetn),
        .pin({capture_d_pin, capture_c_pin, capture_b_pin,
              capture_a_pin, ext_count_clock_pin}),
        .level(),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    // Control field decode
    wire [1:0] clock_select = {control_reg[`CCT_CTL_CKS_HI], control_reg[`CCT_CTL_CKS_LO]};
    wire buffer_a_enable = control_reg[`CCT_CTL_BUFA];
    wire buffer_b_enable = control_reg[`CCT_CTL_BUFB];
    wire auto_add_mode = output_control_reg[`CCT_OCTL_AUTO];
    wire capture_d_mask_mode = output_control_reg[`CCT_OCTL_DMASK];
    wire capture_reg_select = output_control_reg[`CCT_OCTL_CAPSEL];
    wire compare_reg_select = output_control_reg[`CCT_OCTL_CMPSEL];

    // Write strobes per address
    wire wr_ier = wr_hit(wr_en, addr, `CCT_ADDR_IER);
    wire wr_csr = wr_hit(wr_en, addr, `CCT_ADDR_CSR);
    wire wr_cnt = wr_hit(wr_en, addr, `CCT_ADDR_CNT);
    wire wr_cmp = wr_hit(wr_en, addr, `CCT_ADDR_CMP);
    wire wr_ctl = wr_hit(wr_en, addr, `CCT_ADDR_CTL);
    wire wr_octl = wr_hit(wr_en, addr, `CCT_ADDR_OCTL);
    // Capture addresses only write the step/span registers when selected
    wire wr_rise = wr_hit(wr_en, addr, `CCT_ADDR_CAPA) && capture_reg_select;
    wire wr_fall = wr_hit(wr_en, addr, `CCT_ADDR_CAPB) && capture_reg_select;
    wire wr_span = wr_hit(wr_en, addr, `CCT_ADDR_CAPC) && capture_reg_select;

    // Counter tick from the selected source
    reg tick;
    always @* begin
        case (clock_select)
            `CCT_CKS_DIV2: tick = &(prescale | ~`CCT_DIV2_MASK);
            `CCT_CKS_DIV8: tick = &(prescale | ~`CCT_DIV8_MASK);
            `CCT_CKS_DIV32: tick = &(prescale | ~`CCT_DIV32_MASK);
            default: tick = pin_rise[0];
        endcase
    end

    // Matches are judged once per new count value, so a stalled
    // counter does not keep re-firing the same match
    wire match_a = count_moved && (count_value == compare_a_value);
    wire match_b = count_moved && (count_value == compare_b_value);
    wire clear_on_a = match_a && counter_clear_sel;
    wire add_fall_now = add_fall_next || !auto_prev;
    wire overflow = tick && !wr_cnt && !clear_on_a
                    && (count_value == `CCT_CNT_MAX);

    // Capture events; in buffer mode the C and D pins are unused and
    // the A/B pin is watched with the C/D edge select as well
    wire ev_a_own = edge_hit(control_reg[`CCT_CTL_EDGA], pin_rise[1], pin_fall[1]);
    wire ev_a_alt = edge_hit(control_reg[`CCT_CTL_EDGC], pin_rise[1], pin_fall[1]);
    wire ev_b_own = edge_hit(control_reg[`CCT_CTL_EDGB], pin_rise[2], pin_fall[2]);
    wire ev_b_alt = edge_hit(control_reg[`CCT_CTL_EDGD], pin_rise[2], pin_fall[2]);
    wire ev_c = edge_hit(control_reg[`CCT_CTL_EDGC], pin_rise[3], pin_fall[3]);
    wire ev_d = edge_hit(control_reg[`CCT_CTL_EDGD], pin_rise[4], pin_fall[4]);
    wire cap_a = ev_a_own || (buffer_a_enable && ev_a_alt);
    wire cap_b = ev_b_own || (buffer_b_enable && ev_b_alt);
    wire cap_c = !buffer_a_enable && ev_c;
    wire cap_d = !buffer_b_enable && ev_d && !mask_active;
    wire mask_armed = capture_d_mask_mode && (capture_d_mask_span != `CCT_RST_SPAN);

    // Prescaler runs freely
    always @(posedge clock) begin
        if (!resetn) begin
            prescale <= 5'h00;
        end else begin
            prescale <= prescale + 5'h01;
        end
    end

    // Free-running counter; the write wins, then clear, then tick
    always @(posedge clock) begin
        if (!resetn) begin
            count_value <= `CCT_RST_CNT;
            count_moved <= 1'b0;
        end else begin
            count_moved <= wr_cnt || clear_on_a || tick;
            if (wr_cnt) begin
                count_value <= wr_data;
            end else if (clear_on_a) begin
                count_value <= `CCT_RST_CNT;
            end else if (tick) begin
                count_value <= count_value + 16'h0001;
            end
        end
    end

    // Compare registers with the automatic addition on A
    always @(posedge clock) begin
        if (!resetn) begin
            compare_a_value <= `CCT_RST_CMP;
            compare_b_value <= `CCT_RST_CMP;
            add_fall_next <= 1'b1;
            auto_prev <= 1'b0;
        end else begin
            auto_prev <= auto_add_mode;
            // Entering auto mode restarts on the fall step, even with a match
            // in that same cycle
            if (auto_add_mode && match_a) begin
                add_fall_next <= !add_fall_now;
            end else if (auto_add_mode && !auto_prev) begin
                add_fall_next <= 1'b1;
            end
            if (wr_cmp && !compare_reg_select) begin
                compare_a_value <= wr_data;
            end else if (auto_add_mode && match_a) begin
                compare_a_value <= compare_a_value
                    + (add_fall_now ? compare_a_fall_step : compare_a_rise_step);
            end
            if (wr_cmp && compare_reg_select) begin
                compare_b_value <= wr_data;
            end
        end
    end

    // Step and span registers
    always @(posedge clock) begin
        if (!resetn) begin
            compare_a_rise_step <= `CCT_RST_STEP;
            compare_a_fall_step <= `CCT_RST_STEP;
            capture_d_mask_span <= `CCT_RST_SPAN;
        end else begin
            if (wr_rise) begin
                compare_a_rise_step <= wr_data;
            end
            if (wr_fall) begin
                compare_a_fall_step <= wr_data;
            end
            // Only the low byte is stored; the high byte reads zero
            if (wr_span) begin
                capture_d_mask_span <= wr_data[7:0];
            end
        end
    end

    // Capture registers; captures happen whatever the flag holds
    always @(posedge clock) begin
        if (!resetn) begin
            capture_a_value <= `CCT_RST_CAP;
            capture_b_value <= `CCT_RST_CAP;
            capture_c_value <= `CCT_RST_CAP;
            capture_d_value <= `CCT_RST_CAP;
        end else begin
            if (cap_a) begin
                capture_a_value <= count_value;
            end
            if (cap_b) begin
                capture_b_value <= count_value;
            end
            // Buffer takes the old primary value in the same edge
            if (buffer_a_enable && cap_a) begin
                capture_c_value <= capture_a_value;
            end else if (cap_c) begin
                capture_c_value <= count_value;
            end
            if (buffer_b_enable && cap_b) begin
                capture_d_value <= capture_b_value;
            end else if (cap_d) begin
                capture_d_value <= count_value;
            end
        end
    end

    // Capture D mask window; end point is capture plus twice the span
    always @(posedge clock) begin
        if (!resetn) begin
            mask_active <= 1'b0;
            mask_end <= 16'h0000;
        end else begin
            if (cap_d && mask_armed) begin
                mask_active <= 1'b1;
                mask_end <= count_value + {7'h00, capture_d_mask_span, 1'b0};
            end else if (!mask_armed) begin
                mask_active <= 1'b0;
            end else if (count_moved && count_value == mask_end) begin
                mask_active <= 1'b0;
            end
        end
    end

    // Status flags: writing 0 clears, writing 1 keeps; a new event in
    // the clearing cycle still sets the flag so it is never lost
    wire [7:1] flag_set;
    assign flag_set[`CCT_F_CAPA] = cap_a;
    assign flag_set[`CCT_F_CAPB] = cap_b;
    assign flag_set[`CCT_F_CAPC] = cap_c;
    assign flag_set[`CCT_F_CAPD] = cap_d;
    assign flag_set[`CCT_F_CMPA] = match_a;
    assign flag_set[`CCT_F_CMPB] = match_b;
    assign flag_set[`CCT_F_OVF] = overflow;
    wire [7:1] flag_clr = wr_csr ? ~wr_data[7:1] : 7'h00;
    wire [7:1] next_flags = (flags & ~flag_clr) | flag_set;

    // Control, enable and status registers
    always @(posedge clock) begin
        if (!resetn) begin
            interrupt_enable_reg <= 7'h00;
            flags <= 7'h00;
            counter_clear_sel <= 1'b0;
            control_reg <= 8'h00;
            output_control_reg <= 8'h00;
        end else begin
            flags <= next_flags;
            if (wr_ier) begin
                interrupt_enable_reg <= wr_data[7:1];
            end
            if (wr_csr) begin
                counter_clear_sel <= wr_data[`CCT_CSR_CCLR];
            end
            if (wr_ctl) begin
                control_reg <= wr_data[7:0];
            end
            if (wr_octl) begin
                output_control_reg <= wr_data[7:0];
            end
        end
    end

    // Interrupt requests gated by their enables
    always @(posedge clock) begin
        if (!resetn) begin
            irq_req <= 7'h00;
        end else begin
            irq_req <= flags & interrupt_enable_reg;
        end
    end

    // Compare outputs; low from reset until a match drives them
    always @(posedge clock) begin
        if (!resetn) begin
            compare_a_pin <= 1'b0;
            compare_b_pin <= 1'b0;
        end else begin
            if (match_a && output_control_reg[`CCT_OCTL_OEA]) begin
                // Auto mode ignores the level bit: low after a fall add
                if (auto_add_mode) begin
                    compare_a_pin <= !add_fall_now;
                end else begin
                    compare_a_pin <= output_control_reg[`CCT_OCTL_LVLA];
                end
            end
            if (match_b && output_control_reg[`CCT_OCTL_OEB]) begin
                compare_b_pin <= output_control_reg[`CCT_OCTL_LVLB];
            end
        end
    end

    // Read mux, selected by address and select bits
    reg [15:0] next_rd_data;
    always @* begin
        next_rd_data = 16'h0000;
        case (addr)
            `CCT_ADDR_IER: next_rd_data = {8'h00, interrupt_enable_reg, 1'b1};
            `CCT_ADDR_CSR: next_rd_data = {8'h00, flags, counter_clear_sel};
            `CCT_ADDR_CNT: next_rd_data = count_value;
            `CCT_ADDR_CMP: next_rd_data = compare_reg_select ? compare_b_value
                                                             : compare_a_value;
            `CCT_ADDR_CTL: next_rd_data = {8'h00, control_reg};
            `CCT_ADDR_OCTL: next_rd_data = {8'h00, output_control_reg};
            `CCT_ADDR_CAPA: next_rd_data = capture_reg_select ? compare_a_rise_step
                                                              : capture_a_value;
            `CCT_ADDR_CAPB: next_rd_data = capture_reg_select ? compare_a_fall_step
                                                              : capture_b_value;
            `CCT_ADDR_CAPC: next_rd_data = capture_reg_select
                                           ? {8'h00, capture_d_mask_span}
                                           : capture_c_value;
            `CCT_ADDR_CAPD: next_rd_data = capture_d_value;
            default: next_rd_data = 16'h0000;
        endcase
    end

    // Read data stands for one cycle after the strobe, else zero
    always @(posedge clock) begin
        if (!resetn) begin
            rd_data <= 16'h0000;
        end else if (rd_en) begin
            rd_data <= next_rd_data;
        end else begin
            rd_data <= 16'h0000;
        end
    end

endmodule // cct_timer

/* File: testbench/cct_pins.sv */
// Pin-side model: counter clock pin and capture inputs of the timer
`timescale 1ns/1ps
module cct_pins (
    input wire clock,
    output wire ext_count_clock_pin,
    output wire capture_a_pin,
    output wire capture_b_pin,
    output wire capture_c_pin,
    output wire capture_d_pin
);
    reg [3:0] cap = 4'h0;
    reg ext = 1'b0;

    // Pins as separate wires
    assign ext_count_clock_pin = ext;
    assign capture_a_pin = cap[0];
    assign capture_b_pin = cap[1];
    assign capture_c_pin = cap[2];
    assign capture_d_pin = cap[3];

    // Level held four clocks, beyond the both-edge minimum
    task set_cap(input integer i, input reg v);
        begin
            @(posedge clock);
            cap[i] <= v;
            repeat (4) @(posedge clock);
        end
    endtask

    // Clock pin idles low between bursts
    task ext_pulses(input integer n);
        integer k;
        begin
            for (k = 0; k < n; k++) begin
                @(posedge clock);
                ext <= 1'b1;
                repeat (3) @(posedge clock);
                ext <= 1'b0;
                repeat (3) @(posedge clock);
            end
        end
    endtask
endmodule // cct_pins

/* File: testbench/cct_timer_chk.sv */
// Port-level assertions for the capture/compare timer
`timescale 1ns/1ps
module cct_chk (
    input wire clock,
    input wire resetn,
    input wire [3:0] addr,
    input wire [15:0] wr_data,
    input wire wr_en,
    input wire rd_en,
    input wire [15:0] rd_data,
    input wire capture_a_pin,
    input wire compare_a_pin,
    input wire compare_b_pin,
    input wire [6:0] irq_req
);
    reg [7:0] octl_q;
    reg [7:0] ctl_q;
    reg [7:0] ier_q;

    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);

    // Shadow of software control bits, since the checker sees only ports
    always @(posedge clock) begin
        if (!resetn) begin
            octl_q <= 8'h00;
            ctl_q <= 8'h00;
            ier_q <= 8'h00;
        end else if (wr_en) begin
            if (addr == 4'h5) octl_q <= wr_data[7:0];
            if (addr == 4'h4) ctl_q <= wr_data[7:0];
            if (addr == 4'h0) ier_q <= wr_data[7:0];
        end
    end

    AST_PIN_RST: assert property ($past(!resetn) |-> !compare_a_pin && !compare_b_pin)
        else $error("compare pin high after reset");
    AST_RD_IDLE: assert property (!$past(rd_en) |-> rd_data == 16'h0000)
        else $error("read data outside read slot");
    AST_CNT_WR: assert property (wr_en && addr == 4'h2 ##2 rd_en && addr == 4'h2
        |=> 16'(rd_data - $past(wr_data, 3)) <= 16'h0002) else $error("count write lost");
    AST_SPAN_HI: assert property (rd_en && addr == 4'h8 && octl_q[5]
        |=> rd_data[15:8] == 8'h00) else $error("span upper byte not zero");
    AST_OEA: assert property (!octl_q[3] && !$past(octl_q[3]) |-> $stable(compare_a_pin))
        else $error("pin A moved while disabled");
    AST_OEB: assert property (!octl_q[2] && !$past(octl_q[2]) |-> $stable(compare_b_pin))
        else $error("pin B moved while disabled");
    AST_IRQ_MASK: assert property ($stable(ier_q) |-> (irq_req & ~ier_q[7:1]) == 7'h00)
        else $error("request without enable");
    AST_CAP_IRQ: assert property (ier_q[7] && ctl_q[7] && $rose(capture_a_pin)
        |-> ##[2:6] irq_req[6]) else $error("capture A request missing");

    // Main scenarios reached
    COV_RD_CAPD: cover property (rd_en && addr == 4'h9);
    COV_PIN_UP: cover property ($rose(compare_a_pin));
    COV_PIN_DOWN: cover property ($fell(compare_a_pin));
    COV_IRQ: cover property (irq_req[6]);
endmodule // cct_chk

bind cct_timer cct_chk chk_i (.clock(clock), .resetn(resetn), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .capture_a_pin(capture_a_pin), .compare_a_pin(compare_a_pin),
    .compare_b_pin(compare_b_pin), .irq_req(irq_req));

/* File: testbench/tb_top.sv */
// Self-checking bench for the capture/compare timer
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; \
    if ((g) !== (e)) begin n_fail++; \
        $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
    reg clock = 1'b0;
    reg resetn = 1'b0;
    reg [3:0] addr = 4'h0;
    reg [15:0] wr_data = 16'h0000;
    reg wr_en = 1'b0;
    reg rd_en = 1'b0;
    wire [15:0] rd_data;
    wire ext_clk, cap_a, cap_b, cap_c, cap_d, cmp_a, cmp_b;
    wire [6:0] irq_req;
    reg [15:0] d;
    integer n_fail = 0;
    integer compares = 0;
    integer i;

    cct_timer uut (.clock(clock), .resetn(resetn), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .ext_count_clock_pin(ext_clk),
        .capture_a_pin(cap_a), .capture_b_pin(cap_b), .capture_c_pin(cap_c),
        .capture_d_pin(cap_d), .compare_a_pin(cmp_a), .compare_b_pin(cmp_b),
        .irq_req(irq_req));
    cct_pins pins (.clock(clock), .ext_count_clock_pin(ext_clk), .capture_a_pin(cap_a),
        .capture_b_pin(cap_b), .capture_c_pin(cap_c), .capture_d_pin(cap_d));

    // 40 MHz system clock
    initial begin
        forever #12.5 clock = ~clock;
    end

    // Whole 16-bit word accesses only
    task wr(input [3:0] a, input [15:0] v);
        begin
            @(posedge clock);
            wr_en <= 1'b1;
            addr <= a;
            wr_data <= v;
            @(posedge clock);
            wr_en <= 1'b0;
        end
    endtask

    // Data stands only in the cycle after the strobe
    task rd(input [3:0] a);
        begin
            @(posedge clock);
            rd_en <= 1'b1;
            addr <= a;
            @(posedge clock);
            rd_en <= 1'b0;
            #1 d = rd_data;
        end
    endtask

    task rdc(input [3:0] a, input [15:0] e);
        begin
            rd(a);
            `CHK(d, e)
        end
    endtask

    task wrap_up;
        begin
            $display("compares %0d n_fail %0d", compares, n_fail);
            if (n_fail == 0 && compares > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask

    task t_reset;
        begin
            rdc(4'h3, 16'hffff);
            rdc(4'h0, 16'h0001);
            rdc(4'h1, 16'h0000);
            wr(4'h5, 16'h0010);
            rdc(4'h3, 16'hffff);
            wr(4'h3, 16'h5678);
            rdc(4'h3, 16'h5678);
            wr(4'h5, 16'h0020);
            rdc(4'h6, 16'hffff);
            rdc(4'h7, 16'hffff);
            rdc(4'h8, 16'h0000);
            wr(4'h5, 16'h0000);
            rdc(4'h3, 16'hffff);
            for (i = 6; i < 10; i++) rdc(i[3:0], 16'h0000);
            rdc(4'hc, 16'h0000);
        end
    endtask

    // Tick count over 66 edges for each divider, then pin events
    task t_clock;
        integer c, x;
        begin
            for (c = 0; c < 3; c++) begin
                wr(4'h4, c[15:0]);
                wr(4'h2, 16'h0000);
                repeat (64) @(posedge clock);
                rd(4'h2);
                x = 66 >> (2 * c + 1);
                `CHK((d + 1 >= x) && (d <= x + 1), 1'b1)
            end
            wr(4'h4, 16'h0003);
            wr(4'h2, 16'h0000);
            pins.ext_pulses(5);
            rdc(4'h2, 16'h0005);
        end
    endtask

    task t_ovf;
        begin
            wr(4'h4, 16'h0000);
            wr(4'h2, 16'hfff0);
            rd(4'h2);
            `CHK(d[15:1], 15'h7ff8)
            repeat (40) @(posedge clock);
            rd(4'h1);
            `CHK(d[1], 1'b1)
            wr(4'h1, 16'h0000);
            rd(4'h1);
            `CHK(d[1], 1'b0)
        end
    endtask

    task t_cmp;
        begin
            `CHK(cmp_a, 1'b0)
            `CHK(cmp_b, 1'b0)
            wr(4'h1, 16'h0001);
            wr(4'h5, 16'h0010);
            wr(4'h3, 16'h0010);
            wr(4'h5, 16'h000f);
            wr(4'h3, 16'h0020);
            wr(4'h2, 16'h0000);
            repeat (80) @(posedge clock);
            rd(4'h2);
            `CHK(d < 16'h0020, 1'b1)
            rd(4'h1);
            `CHK(d[3], 1'b1)
            `CHK(d[2], 1'b1)
            `CHK(cmp_a, 1'b1)
            `CHK(cmp_b, 1'b1)
        end
    endtask

    // Steps kept well above one while the fast divider runs
    task t_auto;
        begin
            wr(4'h1, 16'h0000);
            wr(4'h5, 16'h0028);
            wr(4'h6, 16'h0010);
            wr(4'h7, 16'h0020);
            wr(4'h3, 16'h0040);
            wr(4'h2, 16'h0000);
            wr(4'h5, 16'h0068);
            repeat (140) @(posedge clock);
            rdc(4'h3, 16'h0060);
            `CHK(cmp_a, 1'b0)
            repeat (60) @(posedge clock);
            rdc(4'h3, 16'h0070);
            `CHK(cmp_a, 1'b1)
        end
    endtask

    // Counter frozen on the idle clock pin, so captures are exact
    task t_cap;
        reg [15:0] v;
        begin
            wr(4'h5, 16'h0000);
            wr(4'h1, 16'h0000);
            wr(4'h0, 16'h0080);
            wr(4'h4, 16'h00a3);
            for (i = 0; i < 4; i++) begin
                v = i[15:0];
                wr(4'h2, 16'h1000 | v);
                pins.set_cap(i, 1'b1);
                wr(4'h2, 16'h2000 | v);
                pins.set_cap(i, 1'b0);
                rdc(4'h6 + v[3:0], (i % 2 == 0) ? (16'h1000 | v) : (16'h2000 | v));
                rd(4'h1);
                `CHK(d[7 - i], 1'b1)
            end
            `CHK(irq_req, 7'h40)
            wr(4'h0, 16'h0000);
            repeat (2) @(posedge clock);
            `CHK(irq_req, 7'h00)
        end
    endtask

    task t_buf;
        begin
            wr(4'h4, 16'h008b);
            wr(4'h2, 16'h0111);
            pins.set_cap(0, 1'b1);
            wr(4'h2, 16'h0222);
            pins.set_cap(0, 1'b0);
            rdc(4'h6, 16'h0222);
            rdc(4'h8, 16'h0111);
        end
    endtask

    task t_mask;
        begin
            wr(4'h4, 16'h0013);
            wr(4'h5, 16'h0020);
            wr(4'h8, 16'hffff);
            rdc(4'h8, 16'h00ff);
            wr(4'h8, 16'h0010);
            wr(4'h5, 16'h0080);
            rdc(4'h8, 16'h0111);
            for (i = 0; i < 2; i++) begin
                wr(4'h2, 16'h0300 + i[15:0]);
                pins.set_cap(3, 1'b1);
                pins.set_cap(3, 1'b0);
                rdc(4'h9, 16'h0300);
            end
            // Count reaching capture plus twice the span ends the window
            wr(4'h2, 16'h0320);
            pins.set_cap(3, 1'b1);
            pins.set_cap(3, 1'b0);
            rdc(4'h9, 16'h0320);
            wr(4'h5, 16'h00a0);
            wr(4'h8, 16'h0000);
            wr(4'h5, 16'h0080);
            wr(4'h2, 16'h0301);
            pins.set_cap(3, 1'b1);
            rdc(4'h9, 16'h0301);
            wr(4'h2, 16'h0302);
            pins.set_cap(3, 1'b0);
            pins.set_cap(3, 1'b1);
            rdc(4'h9, 16'h0302);
        end
    endtask

    // Cut a hang short
    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        wrap_up;
    end

    // Main sequence
    initial begin
        repeat (3) @(posedge clock);
        resetn <= 1'b1;
        t_reset;
        t_clock;
        t_ovf;
        t_cmp;
        t_auto;
        t_cap;
        t_buf;
        t_mask;
        wrap_up;
    end
endmodule // tb_top
